// ---- pcm_far_end.sv ----
// Far-end PCM device: bit or single clock at 48 ns and a receive data line.
// Assumes the bench raises run; the bench may select the clock pin while the clock is running.
`timescale 1ns/1ps
module pcm_far_end (
    // Control from the bench.
    input  wire logic run,
    input  wire logic use_single,
    // Pins towards the block.
    output logic      bit_clock_pin,
    output logic      single_clock_pin_i,
    output logic      rx_data_pin
);
    logic ph;

    // The clock stands low outside frames and starts off the sampling grid.
    // Data is high for the first 34 ns of a cell, so a middle sample reads 1
    // and a three-quarter sample reads 0.
    initial
    begin
        ph = 1'b0;
        rx_data_pin = 1'b0;
        forever
        begin
            wait (run);
            #1;
            while (run)
            begin
                ph = 1'b1;
                rx_data_pin = 1'b1;
                #24 ph = 1'b0;
                #10 rx_data_pin = 1'b0;
                #14;
            end
        end
    end

    // Only the selected clock pin toggles; the other one stays low.
    assign bit_clock_pin      = ph & ~use_single;
    assign single_clock_pin_i = ph & use_single;
endmodule : pcm_far_end

// ---- pcm_frame_pll.sv ----
// Frame timer of the PCM PLL: 8 kHz frame, 512 kHz clock, per-frame phase correction.
// Assumes a one-cycle reference pulse on the same clock.
`timescale 1ns/1ps
`include "pcm_sync_defs.svh"
module pcm_frame_pll #(
    parameter int FRAME_CYC = `FRAME_CYCLES
) (
    // Clock and reset.
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // Reference and settings.
    input  wire logic                   ref_pulse,
    input  wire pcm_sync_pkg::pll_cfg_t cfg,
    // Timer outputs.
    output logic                        clk512,
    output logic                        auto_active
);
    localparam logic [15:0] LAST       = 16'(FRAME_CYC - 1);
    localparam logic [15:0] SLOT_START = 16'(FRAME_CYC - FRAME_CYC / `SLOTS_PER_FRAME);
    localparam logic [15:0] MID        = 16'(FRAME_CYC / 2);
    localparam logic [15:0] HALF_LAST  = 16'(`HALF_512K_CYCLES - 1);

    pcm_sync_pkg::pll_state_t s;
    pcm_sync_pkg::pll_state_t n;
    logic                     avail;

    // Correction in clock cycles: 4, 3, 2 or 1 PCM clock periods by speed code.
    function automatic logic [15:0] adjust_amount(input logic [1:0] sp);
        adjust_amount = 16'((`MAX_ADJUST_STEPS - int'(sp)) * `PCM_CLK_CYCLES);
    endfunction : adjust_amount

    assign avail       = (s.lost < `REF_LOSS_FRAMES);
    assign auto_active = !cfg.manual || avail;
    assign clk512      = s.clk512;

    // One step of the timer; the reference pulse is handled last so it wins.
    always_comb
    begin
        n = s;
        if (s.half == HALF_LAST)
        begin
            n.half   = 16'h0000;
            n.clk512 = !s.clk512;
        end
        else
            n.half = s.half + 16'h0001;
        if (s.stall != 16'h0000)
            n.stall = s.stall - 16'h0001;
        else if (s.cnt == SLOT_START && s.pend)
        begin
            // Corrections only land in the last slot, so no slot is torn.
            n.pend = 1'b0;
            if (s.pdir)
            begin
                // Step on as usual, then hold the count for exactly the amount.
                n.stall = adjust_amount(cfg.speed);
                n.cnt   = s.cnt + 16'h0001;
            end
            else
                n.cnt = s.cnt + adjust_amount(cfg.speed) + 16'h0001;
        end
        else if (s.cnt == LAST)
        begin
            n.cnt  = 16'h0000;
            n.half = 16'h0000;
            if (s.lost != `REF_LOSS_FRAMES)
                n.lost = s.lost + 2'h1;
            if (!auto_active)
            begin
                n.pend = 1'b1;
                n.pdir = cfg.dir;
            end
        end
        else
            n.cnt = s.cnt + 16'h0001;
        if (ref_pulse)
        begin
            n.lost = 2'h0;
            if (s.cnt != 16'h0000)
            begin
                // A reference in our first half means we started early: lengthen, else shorten.
                n.pend = 1'b1;
                n.pdir = (s.cnt < MID);
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s <= '0;
        else
            s <= n;
    end

    shorten_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.stall == 16'h0000 && s.cnt == SLOT_START && s.pend && !s.pdir)
        |=> s.cnt == $past(s.cnt) + adjust_amount($past(cfg.speed)) + 16'h0001)
        else $error("shortening step has the wrong size");
    lengthen_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.stall == 16'h0000 && s.cnt == SLOT_START && s.pend && s.pdir)
        |=> s.stall == adjust_amount($past(cfg.speed)) && s.cnt == $past(s.cnt) + 16'h0001)
        else $error("lengthening stall has the wrong size");
    manual_dir_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.stall == 16'h0000 && s.cnt == LAST && !auto_active && !ref_pulse)
        |=> s.pend && s.pdir == $past(cfg.dir))
        else $error("manual direction not taken at frame end");
    auto_override_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ref_pulse |=> auto_active [*2])
        else $error("manual mode not overridden by a reference");
    auto_track_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (ref_pulse && s.cnt != 16'h0000) |=> s.pend && s.pdir == ($past(s.cnt) < MID))
        else $error("reference did not schedule a correction");
endmodule : pcm_frame_pll

// ---- pcm_sync_defs.svh ----
// Named offsets, field positions, reset values and timing counts for the PCM sync block.
// Included by bare name; definitions only.
`ifndef PCM_SYNC_DEFS_SVH
`define PCM_SYNC_DEFS_SVH
// Timing, in the unit printed, and the cycle counts derived at 4 ns per cycle.
`define CLK_PERIOD_NS     4
`define FRAME_TIME_NS     125000
`define FRAME_CYCLES      (`FRAME_TIME_NS / `CLK_PERIOD_NS)
`define PCM_CLK_PERIOD_PS 244141
`define PCM_CLK_CYCLES    (`PCM_CLK_PERIOD_PS / (`CLK_PERIOD_NS * 1000))
`define HALF_512K_PS      976563
`define HALF_512K_CYCLES  (`HALF_512K_PS / (`CLK_PERIOD_NS * 1000))
`define SLOTS_PER_FRAME   32
`define REF_LOSS_FRAMES   2'h2
`define MAX_ADJUST_STEPS  4
// Register indices; byte address is four times the index.
`define IDX_MODE_ZERO     6'h14
`define IDX_MULTI         6'h15
`define IDX_STATUS        6'h16
`define SEL_MODE_ONE      4'h9
`define SEL_MODE_TWO      4'ha
`define REG_RESET         8'h00
// Field positions.
`define MD0_IDX_HI        7
`define MD0_IDX_LO        4
`define MD1_SMPL          7
`define MD1_ADJ_HI        3
`define MD1_ADJ_LO        2
`define MD2_SYNC_OUT_A    1
`define MD2_REF_SRC       2
`define MD2_SYNC_OUT_B    3
`define MD2_C2O_EN        4
`define MD2_C2I_SEL       5
`define MD2_DIR           6
`define MD2_MAN           7
// Bus answers.
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// ---- pcm_sync_pkg.sv ----
// Types shared by the PCM sync control block and its frame timer.
// Widths follow the constants header.
package pcm_sync_pkg;
    typedef struct packed
    {
        logic       manual;
        logic       dir;
        logic [1:0] speed;
    } pll_cfg_t;

    typedef struct packed
    {
        logic [15:0] cnt;
        logic [15:0] stall;
        logic [15:0] half;
        logic        clk512;
        logic        pend;
        logic        pdir;
        logic [1:0]  lost;
    } pll_state_t;

    typedef struct packed
    {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        aw_hold;
        logic        w_hold;
        logic [5:0]  waddr;
        logic [7:0]  wdata;
        logic        wstrb0;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [7:0]  md0;
        logic [7:0]  md1;
        logic [7:0]  md2;
        logic [2:0]  bclk_s;
        logic [2:0]  sclk_s;
        logic [2:0]  syi_s;
        logic [1:0]  rxd_s;
        logic [9:0]  cell_cnt;
        logic [9:0]  cell_len;
        logic        rx_bit;
        logic        rx_valid;
        logic        sync_out;
        logic        c2_out;
        logic        c2_oe;
        logic        ref_pulse;
    } top_state_t;
endpackage : pcm_sync_pkg

// ---- pcm_sync_pll_control.sv ----
// PCM clock and sync control: AXI4-Lite registers, sample point, sync pin mux, clock select.
// Assumes aclk at 250 MHz; pins are asynchronous, the line and multiframe pulses are on aclk.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "pcm_sync_defs.svh"
module pcm_sync_pll_control #(
    parameter int FRAME_CYC = `FRAME_CYCLES
) (
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write channels.
    input  wire logic [7:0]  s_axil_awaddr,
    input  wire logic        s_axil_awvalid,
    output logic             s_axil_awready,
    input  wire logic [31:0] s_axil_wdata,
    input  wire logic [3:0]  s_axil_wstrb,
    input  wire logic        s_axil_wvalid,
    output logic             s_axil_wready,
    output logic [1:0]       s_axil_bresp,
    output logic             s_axil_bvalid,
    input  wire logic        s_axil_bready,
    // AXI4-Lite read channels.
    input  wire logic [7:0]  s_axil_araddr,
    input  wire logic        s_axil_arvalid,
    output logic             s_axil_arready,
    output logic [31:0]      s_axil_rdata,
    output logic [1:0]       s_axil_rresp,
    output logic             s_axil_rvalid,
    input  wire logic        s_axil_rready,
    // PCM pins.
    input  wire logic        bit_clock_pin,
    input  wire logic        single_clock_pin_i,
    output logic             single_clock_pin_o,
    output logic             single_clock_pin_oe,
    input  wire logic        rx_data_pin,
    input  wire logic        sync_in_pin,
    output logic             sync_out_pin,
    // Pulses from the line and multiframe logic.
    input  wire logic        line_frame_sync_rx,
    input  wire logic        multiframe_sync,
    // Received data.
    output logic             rx_bit,
    output logic             rx_valid
);
    pcm_sync_pkg::top_state_t s;
    pcm_sync_pkg::top_state_t n;
    pcm_sync_pkg::pll_cfg_t   cfg;
    logic                     clk512;
    logic                     auto_active;
    logic                     pclk_edge;
    logic                     sync_pick;

    // Word index of a byte address.
    function automatic logic [5:0] reg_index(input logic [7:0] addr);
        reg_index = addr[7:2];
    endfunction : reg_index

    // Cycle within the bit cell at which the bit is taken.
    function automatic logic [9:0] sample_at(input logic [9:0] len, input logic late);
        sample_at = late ? (len >> 1) + (len >> 2) : (len >> 1);
    endfunction : sample_at

    // Settings handed to the frame timer.
    assign cfg.manual = s.md2[`MD2_MAN];
    assign cfg.dir    = s.md2[`MD2_DIR];
    assign cfg.speed  = s.md1[`MD1_ADJ_HI:`MD1_ADJ_LO];

    pcm_frame_pll #(
        .FRAME_CYC (FRAME_CYC)
    ) u_pll (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .ref_pulse   (s.ref_pulse),
        .cfg         (cfg),
        .clk512      (clk512),
        .auto_active (auto_active)
    );

    // Data clock edges come from the bit clock or the single clock.
    assign pclk_edge = s.md2[`MD2_C2I_SEL] ? (s.sclk_s[1] && !s.sclk_s[2])
                                            : (s.bclk_s[1] && !s.bclk_s[2]);

    // Sync output choice by the two select bits.
    always_comb
    begin
        case ({s.md2[`MD2_SYNC_OUT_A], s.md2[`MD2_SYNC_OUT_B]})
            2'h0:    sync_pick = line_frame_sync_rx;
            2'h1:    sync_pick = s.syi_s[1];
            2'h2:    sync_pick = clk512;
            2'h3:    sync_pick = multiframe_sync;
            default: sync_pick = 1'b0;
        endcase
    end

    // Next state of the whole block: bus slave, pins and sampling.
    always_comb
    begin
        n          = s;
        n.bclk_s   = {s.bclk_s[1:0], bit_clock_pin};
        n.sclk_s   = {s.sclk_s[1:0], single_clock_pin_i};
        n.syi_s    = {s.syi_s[1:0], sync_in_pin};
        n.rxd_s    = {s.rxd_s[0], rx_data_pin};
        n.rx_valid = 1'b0;
        n.sync_out = sync_pick;
        n.c2_out   = clk512;
        n.c2_oe    = s.md2[`MD2_C2O_EN] && !s.md2[`MD2_C2I_SEL];
        // Reference pulse for the timer, chosen by the source bit.
        n.ref_pulse = s.md2[`MD2_REF_SRC] ? (s.syi_s[1] && !s.syi_s[2])
                                          : line_frame_sync_rx;
        // Cell length is measured from edge to edge, so any PCM rate with cells under 1023 cycles works.
        if (pclk_edge)
        begin
            // Counting from one makes the stored count the cell length in cycles.
            n.cell_len = s.cell_cnt;
            n.cell_cnt = 10'h001;
        end
        else
        begin
            if (s.cell_cnt != 10'h3ff)
                n.cell_cnt = s.cell_cnt + 10'h001;
            if (s.cell_cnt == sample_at(s.cell_len, s.md1[`MD1_SMPL]))
            begin
                n.rx_bit   = s.rxd_s[1];
                n.rx_valid = 1'b1;
            end
        end
        // Write address and data are taken in either order.
        if (s.awready && s_axil_awvalid)
        begin
            n.aw_hold = 1'b1;
            n.waddr   = reg_index(s_axil_awaddr);
        end
        if (s.wready && s_axil_wvalid)
        begin
            n.w_hold = 1'b1;
            n.wdata  = s_axil_wdata[7:0];
            n.wstrb0 = s_axil_wstrb[0];
        end
        if (s.bvalid && s_axil_bready)
            n.bvalid = 1'b0;
        if (s.aw_hold && s.w_hold && !s.bvalid)
        begin
            n.aw_hold = 1'b0;
            n.w_hold  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = `RESP_OKAY;
            case (s.waddr)
                `IDX_MODE_ZERO:
                    if (s.wstrb0)
                        n.md0 = s.wdata;
                `IDX_MULTI:
                    // The shared address lands where the index field points.
                    case (s.md0[`MD0_IDX_HI:`MD0_IDX_LO])
                        `SEL_MODE_ONE:
                            if (s.wstrb0)
                                n.md1 = s.wdata;
                        `SEL_MODE_TWO:
                            if (s.wstrb0)
                                n.md2 = s.wdata;
                        default: n.bresp = `RESP_SLVERR;
                    endcase
                default: n.bresp = `RESP_SLVERR;
            endcase
        end
        n.awready = !n.aw_hold;
        n.wready  = !n.w_hold;
        // Reads: settings are write-only and read as zero; status shows live state.
        if (s.rvalid && s_axil_rready)
            n.rvalid = 1'b0;
        if (s.arready && s_axil_arvalid)
        begin
            n.rvalid = 1'b1;
            n.rresp  = `RESP_OKAY;
            n.rdata  = 32'h0000_0000;
            case (reg_index(s_axil_araddr))
                `IDX_MODE_ZERO, `IDX_MULTI: n.rdata = 32'h0000_0000;
                `IDX_STATUS: n.rdata = {28'h0000000, s.c2_oe, s.rx_bit,
                                        clk512, auto_active};
                default: n.rresp = `RESP_SLVERR;
            endcase
        end
        n.arready = !n.rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s <= '0;
        else
            s <= n;
    end

    // Ports straight from the state flops.
    assign s_axil_awready      = s.awready;
    assign s_axil_wready       = s.wready;
    assign s_axil_bvalid       = s.bvalid;
    assign s_axil_bresp        = s.bresp;
    assign s_axil_arready      = s.arready;
    assign s_axil_rvalid       = s.rvalid;
    assign s_axil_rresp        = s.rresp;
    assign s_axil_rdata        = s.rdata;
    assign single_clock_pin_o  = s.c2_out;
    assign single_clock_pin_oe = s.c2_oe;
    assign sync_out_pin        = s.sync_out;
    assign rx_bit              = s.rx_bit;
    assign rx_valid            = s.rx_valid;

    sample_point_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s.rx_valid |-> $past(s.cell_cnt) == sample_at($past(s.cell_len), $past(s.md1[`MD1_SMPL])))
        else $error("bit sampled at the wrong point of the cell");
    sync_mux_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ({s.md2[`MD2_SYNC_OUT_A], s.md2[`MD2_SYNC_OUT_B]} == 2'h2) |=> s.sync_out == $past(clk512))
        else $error("sync output does not follow the 512 kHz clock");
    ref_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!s.md2[`MD2_REF_SRC] && line_frame_sync_rx) |=> s.ref_pulse)
        else $error("line sync not passed as reference");
    single_clk_oe_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s.c2_oe |-> $past(s.md2[`MD2_C2O_EN]) && !$past(s.md2[`MD2_C2I_SEL]))
        else $error("single clock driven while not allowed");
    clock_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s.md2[`MD2_C2I_SEL] && s.sclk_s[1] && !s.sclk_s[2]) |=> s.cell_cnt == 10'h001)
        else $error("single clock edge did not restart the cell");
endmodule : pcm_sync_pll_control

// ---- pcm_sync_pll_control_test.sv ----
// Self-checking bench for the PCM clock and sync control block.
// Assumes the design files and pcm_far_end.sv are compiled first.
`timescale 1ns/1ps
module pcm_sync_pll_control_test;
    // The last slot, a thirty-second of the frame, must hold the largest correction.
    localparam int FRAME = 8000;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, sync_in = 1'b0, line_sync = 1'b0;
    logic        mf_sync = 1'b0, run = 1'b0, use_single = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h1;
    logic        awready, wready, bvalid, arready, rvalid, sclk_o, sclk_oe, sclk_i, far_c2;
    logic        bclk, rxd, sync_out, rx_bit, rx_valid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, rd;
    int          err_total = 0, n_compared = 0;

    // Device under test, with a short frame to keep the run brief.
    pcm_sync_pll_control #(.FRAME_CYC(FRAME)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
        .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb),
        .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
        .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
        .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
        .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
        .bit_clock_pin(bclk), .single_clock_pin_i(sclk_i), .single_clock_pin_o(sclk_o),
        .single_clock_pin_oe(sclk_oe), .rx_data_pin(rxd), .sync_in_pin(sync_in),
        .sync_out_pin(sync_out), .line_frame_sync_rx(line_sync), .multiframe_sync(mf_sync),
        .rx_bit(rx_bit), .rx_valid(rx_valid)
    );

    pcm_far_end i_far (.run(run), .use_single(use_single), .bit_clock_pin(bclk),
        .single_clock_pin_i(far_c2), .rx_data_pin(rxd));

    // The shared pin carries the block's level while it drives, else the far end's.
    assign sclk_i = (sclk_oe === 1'b1) ? sclk_o : far_c2;

    // A 4 ns clock.
    always #2 aclk = ~aclk;

    // Compare one value with its expectation and log a mismatch.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // One write; each valid drops once taken and bready stays up until the answer.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] exp);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        // Only the watchdog ends a wait for an answer that never comes.
        forever
        begin
            @(posedge aclk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
                break;
        end
        check(bresp, exp);
        bready <= 1'b0;
    endtask : wr

    // One read; the word lands in rd.
    task automatic rdr(input logic [7:0] a, input logic [1:0] exp);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (arready === 1'b1)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
                break;
        end
        rd = rdata;
        check(rresp, exp);
        rready <= 1'b0;
    endtask : rdr

    // Select a multi-register through the index field, then write it.
    task automatic set_multi(input logic [3:0] idx, input logic [7:0] v);
        wr(8'h50, {idx, 4'h0}, 2'h0);
        wr(8'h54, v, 2'h0);
    endtask : set_multi

    // Wait for the third sample pulse, so the measured cell length has settled.
    task automatic wait_rx(output logic got);
        int k;
        k = 0;
        repeat (200)
        begin
            @(posedge aclk);
            if (rx_valid === 1'b1)
                k++;
            if (k == 3)
                break;
        end
        got = (k == 3);
    endtask : wait_rx

    // Reset values, refused writes and an unmapped read.
    task automatic t_regs;
        rdr(8'h54, 2'h0);
        check(rd, 32'h0);
        rdr(8'h40, 2'h2);
        wr(8'h50, 8'h30, 2'h0);
        wr(8'h54, 8'h10, 2'h2);
        wr(8'h58, 8'h01, 2'h2);
        check(sclk_oe, 1'b0);
    endtask : t_regs

    // Output enable of the single-clock pin for all four enable and select pairs.
    task automatic t_oe;
        set_multi(4'ha, 8'h00);
        wstrb <= 4'h0;
        wr(8'h54, 8'h10, 2'h0);
        wstrb <= 4'h1;
        repeat (2) @(posedge aclk);
        check(sclk_oe, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            set_multi(4'ha, {2'h0, i[1:0], 4'h0});
            repeat (2) @(posedge aclk);
            check(sclk_oe, i == 1);
            rdr(8'h58, 2'h0);
            check(rd[3], i == 1);
        end
    endtask : t_oe

    // Each select code passes its own source; the others are driven opposite.
    task automatic t_sync_out;
        logic s0, s1;
        for (int c = 0; c < 4; c++)
        begin
            set_multi(4'ha, {4'h0, c[0], 1'b0, c[1], 1'b0});
            for (int l = 0; l < 2; l++)
            begin
                line_sync <= (c == 0) ? l[0] : ~l[0];
                sync_in   <= (c == 1) ? l[0] : ~l[0];
                mf_sync   <= (c == 3) ? l[0] : ~l[0];
                repeat (8) @(posedge aclk);
                if (c != 2)
                    check(sync_out, l[0]);
            end
            s0 = 1'b0;
            s1 = 1'b0;
            repeat ((c == 2) ? 600 : 0)
            begin
                @(posedge aclk);
                s0 = s0 | (sync_out === 1'b0);
                s1 = s1 | (sync_out === 1'b1);
            end
            if (c == 2)
            begin
                check({s0, s1}, 2'b11);
                check(sclk_o, sync_out);
            end
        end
        line_sync <= 1'b0;
        sync_in   <= 1'b0;
        mf_sync   <= 1'b0;
    endtask : t_sync_out

    // Give n reference pulses on the pin or the line, or none for two frames and a margin,
    // then compare the tracking flag in the status word.
    task automatic ref_check(input logic pin, input int n, input logic exp);
        repeat (n)
        begin
            line_sync <= ~pin;
            sync_in   <= pin;
            @(posedge aclk);
            line_sync <= 1'b0;
            repeat (8) @(posedge aclk);
            sync_in <= 1'b0;
            repeat (FRAME / 2) @(posedge aclk);
        end
        repeat ((n == 0) ? 2 * FRAME + 1000 : 0) @(posedge aclk);
        rdr(8'h58, 2'h0);
        check(rd[0], exp);
    endtask : ref_check

    // Manual mode with and without a reference, on both sources, then automatic.
    task automatic t_pll;
        set_multi(4'ha, 8'h84);
        ref_check(1'b0, 0, 1'b0);
        ref_check(1'b0, 2, 1'b0);
        ref_check(1'b1, 2, 1'b1);
        set_multi(4'ha, 8'h80);
        ref_check(1'b0, 0, 1'b0);
        ref_check(1'b0, 2, 1'b1);
        set_multi(4'ha, 8'h00);
        ref_check(1'b0, 0, 1'b1);
    endtask : t_pll

    // Sample point and the choice between the two clock pins.
    task automatic t_sample;
        logic got;
        run <= 1'b1;
        set_multi(4'h9, 8'h00);
        wait_rx(got);
        check({got, rx_bit}, 2'b11);
        set_multi(4'h9, 8'h80);
        wait_rx(got);
        check({got, rx_bit}, 2'b10);
        use_single <= 1'b1;
        wait_rx(got);
        check(got, 1'b0);
        set_multi(4'ha, 8'h20);
        wait_rx(got);
        check({got, rx_bit}, 2'b10);
        run <= 1'b0;
    endtask : t_sample

    // Print the counts and the verdict, then stop.
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // Main sequence: five cycles of reset, then the scenarios.
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs;
        t_oe;
        t_sync_out;
        t_pll;
        t_sample;
        wrap_up;
    end

    // Watchdog at 100,000 cycles, beyond the roughly 76,000 expected, so a hang still ends the run.
    initial
    begin
        #400000;
        err_total++;
        wrap_up;
    end
endmodule : pcm_sync_pll_control_test
